// file: logic/event_counter.sv
// Programmable up/down event counter with capture, compare and reload control
//
// Function
// - Capture mode none builds no capture logic and ignores the capture input.
// - Copy count on selected capture edge: rising, falling or either.
// - Software capture mode takes the edge from the control register field.
// - Software enable: counting gated by control enable bit only.
// - Hardware enable: counting gated by enable input only.
// - Combined enable: count only while input and control bit both active.
// - Continuous mode keeps counting through terminal count while enabled.
// - One-shot halts after one period; restarts on a rising edge of the reset input.
// - One-shot halt loads period (programmable) or holds terminal count (fixed).
// - Reload sets zero in up clock mode, period in down, direction and up/down clock modes.
// - Reload trigger is OR of enabled capture, compare, reset, terminal sources.
// - Reload on capture, default off, programmable variant only.
// - Reload on compare true, default off, programmable variant only.
// - Reload on reset event, default on, programmable variant only.
// - Reload on overflow or underflow, default on, programmable variant only.
// - Separate up/down inputs reload period at zero or all ones.
// - Interrupt sources individually enabled, ORed, changeable by software.
// - Terminal interrupt always exists; capture and compare need programmable variant.
// - Compare output evaluates count against compare value each cycle.
// - Interrupt output is OR of enabled compare, terminal, capture flags.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "counter_consts.svh"

module event_counter
    import counter_pkg::*;
#(
    parameter capture_mode_e CAPTURE_MODE = cap_rising,
    parameter enable_mode_e  ENABLE_MODE  = en_soft,
    parameter clock_mode_e   CLOCK_MODE   = clk_up,
    parameter bit            ONE_SHOT     = 1'b0,
    parameter bit            PROG_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // Avalon-MM slave
    input  wire logic [5:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    // Event inputs
    input  wire logic                   count_input,
    input  wire logic                   direction_up,
    input  wire logic                   increment_input,
    input  wire logic                   decrement_input,
    input  wire logic                   enable_input,
    input  wire logic                   reset_input,
    input  wire logic                   capture_input,
    // Outputs
    output logic                        compare_out,
    output logic                        terminal_count,
    output logic                        interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [`CNT_WIDTH-1:0] count, next_count;
    logic [`CNT_WIDTH-1:0] period, next_period;
    logic [`CNT_WIDTH-1:0] compare_value, next_compare_value;
    logic [`CNT_WIDTH-1:0] capture_value, next_capture_value;
    logic                  ctrl_enable, next_ctrl_enable;
    compare_mode_e         cmp_mode, next_cmp_mode;
    capture_mode_e         cap_field, next_cap_field;
    logic [3:0]            reload_sel, next_reload_sel;
    logic [2:0]            irq_mask, next_irq_mask;
    logic [2:0]            status, next_status;
    run_state_e            run_state, next_run_state;
    logic                  count_prev, up_prev, down_prev, rst_prev;
    logic                  next_count_prev, next_up_prev, next_down_prev, next_rst_prev;
    logic                  compare_prev, next_compare_prev;
    logic                  ack, next_ack;
    logic [31:0]           next_readdata;

    logic                  capture_event;
    logic                  enabled, step_up, step_down, at_terminal, tc_event;
    logic                  reset_event, compare_rise, reload;
    logic [`CNT_WIDTH-1:0] start_value;
    logic [3:0]            reg_index;
    logic                  wr_hit;
    logic [31:0]           wmask;

    assign reg_index = avs_address[5:2];
    // Write lands at the answer edge, when waitrequest is low
    assign wr_hit    = avs_write & ack;

    ////////////////////////////////////////////////////////////////////////
    // Capture edge detection
    generate
        if (CAPTURE_MODE == cap_none) begin : g_no_capture
            assign capture_event = 1'b0;
        end else begin : g_capture
            capture_mode_e edge_sel;
            assign edge_sel = (CAPTURE_MODE == cap_soft) ? cap_field : CAPTURE_MODE;
            edge_capture u_edge (
                .mclk          (mclk),
                .reset         (reset),
                .capture_in    (capture_input),
                .edge_mode     (edge_sel),
                .capture_event (capture_event)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Enable, count steps and compare
    always_comb begin
        case (ENABLE_MODE)
            en_soft: enabled = ctrl_enable;
            en_hard: enabled = enable_input;
            en_both: enabled = ctrl_enable & enable_input;
            default: enabled = 1'b0;
        endcase
        if (run_state == run_halted) begin
            enabled = 1'b0;
        end
        step_up   = 1'b0;
        step_down = 1'b0;
        case (CLOCK_MODE)
            clk_up:     step_up = count_input & ~count_prev;
            clk_down:   step_down = count_input & ~count_prev;
            clk_dir: begin
                step_up   = count_input & ~count_prev & direction_up;
                step_down = count_input & ~count_prev & ~direction_up;
            end
            clk_updown: begin
                step_up   = increment_input & ~up_prev;
                step_down = decrement_input & ~down_prev;
            end
            default: ;
        endcase
        step_up   = step_up & enabled;
        step_down = step_down & enabled;
        case (cmp_mode)
            cmp_lt:  compare_out = count < compare_value;
            cmp_le:  compare_out = count <= compare_value;
            cmp_eq:  compare_out = count == compare_value;
            cmp_gt:  compare_out = count > compare_value;
            cmp_ge:  compare_out = count >= compare_value;
            default: compare_out = 1'b0;
        endcase
    end

    // Terminal count detection per direction
    always_comb begin
        if (CLOCK_MODE == clk_down) begin
            at_terminal = count == `CNT_ZERO;
            tc_event    = step_down & at_terminal;
        end else if (CLOCK_MODE == clk_up) begin
            at_terminal = count == period;
            tc_event    = step_up & at_terminal;
        end else begin
            // zero or all ones in bidirectional modes
            at_terminal = (count == `CNT_ZERO) | (count == `CNT_ALL_ONES);
            tc_event    = enabled & at_terminal;
        end
        terminal_count = at_terminal;
        start_value  = (CLOCK_MODE == clk_up) ? `CNT_ZERO : period;
        reset_event  = reset_input & ~rst_prev;
        compare_rise = compare_out & ~compare_prev;
        reload = (PROG_VARIANT & reload_sel[`RL_CAP_BIT] & capture_event)
               | (PROG_VARIANT & reload_sel[`RL_CMP_BIT] & compare_rise)
               | (PROG_VARIANT & reload_sel[`RL_RST_BIT] & reset_event)
               | (PROG_VARIANT & reload_sel[`RL_TC_BIT] & tc_event)
               | ((CLOCK_MODE == clk_updown) & tc_event);
    end

    ////////////////////////////////////////////////////////////////////////
    // Count, run state and edge history
    always_comb begin
        next_count        = count;
        next_run_state    = run_state;
        next_count_prev   = count_input;
        next_up_prev      = increment_input;
        next_down_prev    = decrement_input;
        next_rst_prev     = reset_input;
        next_compare_prev = compare_out;
        next_capture_value = capture_value;
        if (capture_event) begin
            next_capture_value = count;
        end
        if (reset_input) begin
            // Held reset keeps the counter at its start value, or at its count when reset reload is off
            next_count = (PROG_VARIANT & ~reload_sel[`RL_RST_BIT]) ? count : start_value;
            if (ONE_SHOT & reset_event) begin
                next_run_state = run_counting;
            end
        end else if (ONE_SHOT && tc_event && run_state == run_counting) begin
            // halt after one period, variant-specific end value
            next_run_state = run_halted;
            next_count     = PROG_VARIANT ? period : count;
        end else if (reload) begin
            next_count = (CLOCK_MODE == clk_updown) ? period : start_value;
        end else if (tc_event && !PROG_VARIANT) begin
            // fixed variant wraps to start value
            next_count = start_value;
        end else if (step_up & ~step_down) begin
            next_count = count + 8'h01;
        end else if (step_down & ~step_up) begin
            next_count = count - 8'h01;
        end
        if (wr_hit && reg_index == `REG_COUNT && avs_byteenable[0]) begin
            next_count = avs_writedata[`CNT_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            count         <= (CLOCK_MODE == clk_up) ? `CNT_ZERO : `CNT_PERIOD_RST;
            run_state     <= run_counting;
            count_prev    <= 1'b0;
            up_prev       <= 1'b0;
            down_prev     <= 1'b0;
            rst_prev      <= 1'b0;
            compare_prev  <= next_compare_prev; // No false compare event at release
            capture_value <= `CNT_ZERO;
        end else begin
            count         <= next_count;
            run_state     <= next_run_state;
            count_prev    <= next_count_prev;
            up_prev       <= next_up_prev;
            down_prev     <= next_down_prev;
            rst_prev      <= next_rst_prev;
            compare_prev  <= next_compare_prev;
            capture_value <= next_capture_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers, status flags and bus answer
    always_comb begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        next_ctrl_enable   = ctrl_enable;
        next_cmp_mode      = cmp_mode;
        next_cap_field     = cap_field;
        next_period        = period;
        next_compare_value = compare_value;
        next_reload_sel    = reload_sel;
        next_irq_mask      = irq_mask;
        next_status        = status;
        next_ack           = (avs_read | avs_write) & ~ack;
        next_readdata      = 32'h0000_0000;
        if (wr_hit) begin
            case (reg_index)
                `REG_CTRL: if (avs_byteenable[0]) begin
                    next_ctrl_enable = avs_writedata[`CTRL_ENABLE_BIT];
                    next_cmp_mode    = compare_mode_e'(avs_writedata[`CTRL_CMPMODE_LSB +: 3]);
                    next_cap_field   = capture_mode_e'(avs_writedata[`CTRL_CAPMODE_LSB +: 3]);
                end
                `REG_PERIOD:   if (avs_byteenable[0]) next_period = avs_writedata[7:0];
                `REG_COMPARE:  if (avs_byteenable[0]) next_compare_value = avs_writedata[7:0];
                `REG_STATUS:   next_status = status & ~(avs_writedata[2:0] & wmask[2:0]);
                // software changes interrupt sources any time
                `REG_IRQ_MASK: if (avs_byteenable[0]) next_irq_mask = avs_writedata[2:0];
                `REG_RELOAD:   if (avs_byteenable[0]) next_reload_sel = avs_writedata[3:0];
                default: ;
            endcase
        end
        // events set flags, set wins over clear
        if (tc_event)     next_status[`ST_TC_BIT]  = 1'b1;
        if (compare_rise) next_status[`ST_CMP_BIT] = 1'b1;
        if (capture_event) next_status[`ST_CAP_BIT] = 1'b1;
        if (avs_read && !ack) begin
            case (reg_index)
                `REG_CTRL:     next_readdata = {25'h0, cap_field, cmp_mode, ctrl_enable};
                `REG_PERIOD:   next_readdata = {24'h0, period};
                `REG_COMPARE:  next_readdata = {24'h0, compare_value};
                `REG_COUNT:    next_readdata = {24'h0, count};
                `REG_CAPTURE:  next_readdata = {24'h0, capture_value};
                `REG_STATUS:   next_readdata = {28'h0, run_state == run_halted, status};
                `REG_IRQ_MASK: next_readdata = {29'h0, irq_mask};
                `REG_RELOAD:   next_readdata = {28'h0, reload_sel};
                default:       next_readdata = 32'h0000_0000;
            endcase
        end
        avs_waitrequest = (avs_read | avs_write) & ~ack;
        // OR of enabled flags, variant gating
        interrupt = (irq_mask[`ST_TC_BIT] & status[`ST_TC_BIT])
                  | (PROG_VARIANT & irq_mask[`ST_CMP_BIT] & status[`ST_CMP_BIT])
                  | (PROG_VARIANT & irq_mask[`ST_CAP_BIT] & status[`ST_CAP_BIT]);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_enable   <= 1'b0;
            cmp_mode      <= cmp_lt;
            cap_field     <= cap_rising;
            period        <= `CNT_PERIOD_RST;
            compare_value <= `CNT_COMPARE_RST;
            reload_sel    <= `RELOAD_RST;
            irq_mask      <= `IRQ_MASK_RST;
            status        <= 3'h0;
            ack           <= 1'b0;
            avs_readdata  <= 32'h0000_0000;
        end else begin
            ctrl_enable   <= next_ctrl_enable;
            cmp_mode      <= next_cmp_mode;
            cap_field     <= next_cap_field;
            period        <= next_period;
            compare_value <= next_compare_value;
            reload_sel    <= next_reload_sel;
            irq_mask      <= next_irq_mask;
            status        <= next_status;
            ack           <= next_ack;
            avs_readdata  <= next_readdata;
        end
    end

endmodule

`default_nettype wire

// file: common/counter_consts.svh
// Register offsets, field positions, reset values and widths of the event counter
`ifndef COUNTER_CONSTS_SVH
`define COUNTER_CONSTS_SVH

`define CNT_WIDTH          8
`define CNT_ALL_ONES       8'hff
`define CNT_ZERO           8'h00
`define CNT_PERIOD_RST     8'hff
`define CNT_COMPARE_RST    8'h80

// Low four bits of the byte addresses on the word-wide bus
`define ADDR_CTRL          4'h0
`define ADDR_PERIOD        4'h4
`define ADDR_COMPARE       4'h8
`define ADDR_COUNT         4'hc
`define ADDR_CAPTURE       4'h0
`define ADDR_STATUS        4'h4
`define ADDR_IRQ_MASK      4'h8

// Word index decode uses address bits 5:2
`define REG_CTRL           4'h0
`define REG_PERIOD         4'h1
`define REG_COMPARE        4'h2
`define REG_COUNT          4'h3
`define REG_CAPTURE        4'h4
`define REG_STATUS         4'h5
`define REG_IRQ_MASK       4'h6
`define REG_RELOAD         4'h7

// Control register fields
`define CTRL_ENABLE_BIT    0
`define CTRL_CMPMODE_LSB   1
`define CTRL_CAPMODE_LSB   4
`define CTRL_RST           32'h0000_0010

// Status / mask bit positions
`define ST_TC_BIT          0
`define ST_CMP_BIT         1
`define ST_CAP_BIT         2

// Reload selection bits and reset value (reset and terminal count on)
`define RL_CAP_BIT         0
`define RL_CMP_BIT         1
`define RL_RST_BIT         2
`define RL_TC_BIT          3
`define RELOAD_RST         4'hc
`define IRQ_MASK_RST       3'h0

`endif

// file: common/counter_pkg.sv
// Types shared by the event counter design
package counter_pkg;

    typedef enum logic [2:0] {
        cap_none    = 3'h0,
        cap_rising  = 3'h1,
        cap_falling = 3'h2,
        cap_either  = 3'h3,
        cap_soft    = 3'h4
    } capture_mode_e;

    typedef enum logic [2:0] {
        cmp_lt = 3'h0,
        cmp_le = 3'h1,
        cmp_eq = 3'h2,
        cmp_gt = 3'h3,
        cmp_ge = 3'h4
    } compare_mode_e;

    typedef enum logic [1:0] {
        en_soft = 2'h0,
        en_hard = 2'h1,
        en_both = 2'h2
    } enable_mode_e;

    typedef enum logic [1:0] {
        clk_up     = 2'h0,
        clk_down   = 2'h1,
        clk_dir    = 2'h2,
        clk_updown = 2'h3
    } clock_mode_e;

    typedef enum logic [1:0] {
        run_counting = 2'b01,
        run_halted   = 2'b10
    } run_state_e;

endpackage

// file: logic/edge_capture.sv
// Edge detector that flags the configured edges of the capture input
`timescale 1ns/10ps
`default_nettype none

module edge_capture
    import counter_pkg::*;
(
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          reset,
    // Capture input and selected edge
    input  wire logic          capture_in,
    input  wire capture_mode_e edge_mode,
    // One-cycle capture event
    output logic               capture_event
);

    logic prev_level;
    logic next_prev_level;

    // Previous level of the capture input
    always_comb begin
        next_prev_level = capture_in;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= next_prev_level;
        end
    end

    always_comb begin
        case (edge_mode)
            cap_rising:  capture_event = capture_in & ~prev_level;
            cap_falling: capture_event = ~capture_in & prev_level;
            cap_either:  capture_event = capture_in ^ prev_level;
            default:     capture_event = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// file: dv/counter_properties.sv
// Port-level properties of the event counter
`timescale 1ns/10ps
`default_nettype none

module counter_properties (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Register bus
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // Events and outputs
    input  wire logic        count_input,
    input  wire logic        capture_input,
    input  wire logic        reset_input,
    input  wire logic        compare_out,
    input  wire logic        terminal_count,
    input  wire logic        interrupt
);
    logic       req;
    logic       quiet;
    logic [7:0] period_shadow;
    logic [7:0] next_period_shadow;

    // Request and no-disturbance helpers
    assign req   = avs_read | avs_write;
    assign quiet = !avs_write && !reset_input;

    // Shadow of the last period written
    always_comb begin
        next_period_shadow = period_shadow;
        if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[5:2] == 4'h1) begin
            next_period_shadow = avs_writedata[7:0];
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            period_shadow <= 8'hff;
        end else begin
            period_shadow <= next_period_shadow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request waited more than one cycle");
    AST_WAIT_NEXT: assert property ((req && !avs_waitrequest) ##1 !req ##1 req |-> avs_waitrequest)
        else $error("back to back request answered without wait");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[5] |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_PERIOD_RB: assert property (avs_read && !avs_waitrequest && avs_address[5:2] == 4'h1
        |-> avs_readdata[7:0] == period_shadow)
        else $error("period readback differs from last write");
    AST_RST_CMP: assert property ($fell(reset) |-> compare_out)
        else $error("compare output low after reset");
    AST_RST_IDLE: assert property ($fell(reset) |-> !terminal_count && !interrupt)
        else $error("terminal or interrupt high after reset");
    AST_QUIET_OUT: assert property (($stable(count_input) && $stable(capture_input) && quiet)[*5]
        |-> $stable(compare_out) && $stable(terminal_count))
        else $error("outputs moved without any event");
    AST_QUIET_IRQ: assert property (($stable(count_input) && $stable(capture_input) && quiet)[*5]
        |-> $stable(interrupt))
        else $error("interrupt moved without any event");
endmodule

bind event_counter counter_properties u_props (
    .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_input(count_input), .capture_input(capture_input), .reset_input(reset_input),
    .compare_out(compare_out), .terminal_count(terminal_count), .interrupt(interrupt)
);

`default_nettype wire

// file: dv/event_source.sv
// Model of the event source feeding the count input
`timescale 1ns/10ps
`default_nettype none

module event_source (
    // Clock and control
    input  wire logic mclk,
    input  wire logic run,
    // Count events
    output logic      count_input
);
    always @(posedge mclk) begin
        count_input <= run ? ~count_input : 1'b0;
    end
endmodule

`default_nettype wire

// file: dv/tb.sv
// Self-checking testbench of the event counter
`timescale 1ns/10ps
`default_nettype none
`include "counter_consts.svh"

module tb
    import counter_pkg::*;
;
    logic        mclk, reset, avs_read, avs_write, avs_waitrequest, run;
    logic        count_input, enable_input, reset_input, capture_input;
    logic        compare_out, terminal_count, interrupt;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    int          n_fail, tests_run;
    logic [7:0]  rst_exp [9] = '{8'h10, 8'hff, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h00};
    logic [4:0]  cmp_exp [2] = '{5'b10110, 5'b00011};

    // Device under test, software capture mode
    event_counter #(.CAPTURE_MODE(cap_soft)) u_dut (
        .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .count_input(count_input), .direction_up(1'b1), .increment_input(1'b0),
        .decrement_input(1'b0), .enable_input(enable_input), .reset_input(reset_input),
        .capture_input(capture_input), .compare_out(compare_out),
        .terminal_count(terminal_count), .interrupt(interrupt)
    );
    event_source u_src (.mclk(mclk), .run(run), .count_input(count_input));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d);
        @(posedge mclk);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(q[7:0], exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Send n rising edges on the count input
    task automatic pulse(input int n);
        run <= 1'b1;
        idle(2 * n);
        run <= 1'b0;
        idle(4);
    endtask

    // Look at the interrupt mid-cycle
    task automatic irq_chk(input logic exp);
        @(negedge mclk);
        check({7'h0, interrupt}, {7'h0, exp});
        @(posedge mclk);
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        {reset, avs_read, avs_write, run, enable_input, reset_input, capture_input} = 7'h40;
        avs_address   = 6'h00;
        avs_writedata = 32'h0;
        n_fail        = 0;
        tests_run     = 0;
        idle(3);
        reset <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i != 4) rd_chk(i[3:0], rst_exp[i]);
        end
        // Enable input ignored, control bit rules
        enable_input <= 1'b1;
        pulse(3);
        rd_chk(`REG_COUNT, 8'h00);
        wr(`REG_CTRL, 8'h01);
        enable_input <= 1'b0;
        pulse(3);
        rd_chk(`REG_COUNT, 8'h03);
        // Wrap through terminal count at period 4
        wr(`REG_PERIOD, 8'h04);
        wr(`REG_COUNT, 8'h00);
        wr(`REG_STATUS, 8'h07);
        pulse(6);
        rd_chk(`REG_COUNT, 8'h01);
        bus(1'b0, `REG_STATUS, 8'h00);
        check({7'h0, q[`ST_TC_BIT]}, 8'h01);
        wr(`REG_COUNT, 8'h04);
        @(negedge mclk) check({7'h0, terminal_count}, 8'h01);
        // Every compare relation at equal and one above
        wr(`REG_CTRL, 8'h00);
        wr(`REG_COUNT, 8'h40);
        for (int c = 0; c < 2; c++) begin
            wr(`REG_COMPARE, 8'h40 + c[7:0]);
            for (int m = 0; m < 5; m++) begin
                wr(`REG_CTRL, {4'h0, m[2:0], 1'b0});
                @(negedge mclk);
                check({7'h0, compare_out}, {7'h0, cmp_exp[c][m]});
            end
        end
        // Falling-edge capture chosen by software
        wr(`REG_CTRL, 8'h20);
        wr(`REG_STATUS, 8'h07);
        wr(`REG_IRQ_MASK, 8'h04);
        capture_input <= 1'b1;
        idle(4);
        bus(1'b0, `REG_STATUS, 8'h00);
        check({7'h0, q[`ST_CAP_BIT]}, 8'h00);
        irq_chk(1'b0);
        capture_input <= 1'b0;
        idle(4);
        rd_chk(`REG_CAPTURE, 8'h40);
        irq_chk(1'b1);
        wr(`REG_IRQ_MASK, 8'h00);
        irq_chk(1'b0);
        wr(`REG_IRQ_MASK, 8'h04);
        irq_chk(1'b1);
        wr(`REG_STATUS, 8'h04);
        irq_chk(1'b0);
        // Reload on capture added to the sources
        wr(`REG_RELOAD, 8'h0d);
        capture_input <= 1'b1;
        idle(2);
        capture_input <= 1'b0;
        idle(4);
        rd_chk(`REG_COUNT, 8'h00);
        // Reload while the reset input is high
        wr(`REG_COUNT, 8'h22);
        reset_input <= 1'b1;
        idle(3);
        reset_input <= 1'b0;
        idle(2);
        rd_chk(`REG_COUNT, 8'h00);
        final_report();
    end
endmodule

`default_nettype wire
